// >>> rtl/lhp_host_port.sv
// parallel host port and register map of the four-channel line interface
`timescale 1ns/1ps
// Contract
// - split strobes: read strobe low with select low reads; device drives data.
// - direction style: low strobe with select low marks access; direction picks kind.
// - split strobes: write strobe low with select low writes; device captures data.
// - direction style: direction high means read, low means write.
// - split strobes: ready goes high when the access is finished.
// - direction style: acknowledge goes low when the access is finished.
// - interrupt pin low on enabled alarm; held inactive while global enable is off.
// - decode 128 byte locations, each reachable by single accesses.
// - each of four channels owns sixteen consecutive control and status registers.
// - channel n bank starts at n times sixteen.
// - four registers after the banks are global command controls.
// - eight readable and writable test registers follow the global controls.
// - span up to identity registers is reserved, no user function.
// - top two locations return fixed identity code and revision.
module lhp_host_port #(
  parameter int                          NUM_CH     = 4,
  parameter logic [lhp_pkg::DATA_W-1:0]  DEVICE_ID  = 8'h5A, // arbitrary value
  parameter logic [lhp_pkg::DATA_W-1:0]  REVISION   = 8'h01  // arbitrary value
) (
  input  wire logic                                      clk_i,
  input  wire logic                                      rst_n_i,
  input  wire logic                                      ce_i,
  input  wire logic                                      bus_style_i,
  input  wire lhp_pkg::lhp_pins_t                        host_i,
  input  wire logic [NUM_CH-1:0][lhp_pkg::FLAG_W-1:0]    alarm_live_i,
  input  wire logic [NUM_CH-1:0][lhp_pkg::CLOSS_W-1:0]   cable_loss_i,
  output logic      [lhp_pkg::DATA_W-1:0]                data_o,
  output logic                                           data_oe_n_o,
  output logic                                           access_done_handshake_o,
  output logic                                           irq_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // access detection

  lhp_pkg::lhp_state_t state;
  lhp_pkg::lhp_state_t next_state;
  lhp_pkg::lhp_acc_t   acc;

  wire logic selected  = !host_i.cs_n;
  wire logic style_dir = (bus_style_i == lhp_pkg::STYLE_DIR);
  wire logic dir_on    = selected && !host_i.read_or_data_strobe_n;
  wire logic split_on  = selected && (!host_i.read_or_data_strobe_n || !host_i.wr_rw);
  wire logic access_on = style_dir ? dir_on : split_on;
  // direction line picks read or write in direction style, read strobe in split style
  wire logic access_rd = style_dir ? host_i.wr_rw : !host_i.read_or_data_strobe_n;

  always_comb begin
    next_state = state;
    unique case (state)
      lhp_pkg::ST_IDLE: if (access_on) next_state = lhp_pkg::ST_TAKE;
      lhp_pkg::ST_TAKE: next_state = lhp_pkg::ST_LOAD;
      lhp_pkg::ST_LOAD: next_state = lhp_pkg::ST_DONE;
      lhp_pkg::ST_DONE: if (!access_on) next_state = lhp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= lhp_pkg::ST_IDLE;
      acc   <= '0;
    end else if (ce_i) begin
      state <= next_state;
      if (state == lhp_pkg::ST_IDLE) begin
        acc.rd   <= access_rd;
        acc.addr <= host_i.addr[lhp_pkg::ADDR_W-1:0];
        acc.data <= host_i.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // seven low address bits select one of 128 bytes
  wire logic [3:0] reg_idx  = acc.addr[3:0];
  wire logic [1:0] ch_idx   = acc.addr[5:4];
  wire logic in_chan  = (acc.addr <= lhp_pkg::CH_LAST);
  wire logic is_live  = in_chan && (reg_idx == lhp_pkg::REG_LIVE);
  wire logic is_latch = in_chan && (reg_idx == lhp_pkg::REG_LATCH);
  wire logic is_closs = in_chan && (reg_idx == lhp_pkg::REG_CLOSS);
  wire logic is_irqen = in_chan && (reg_idx == lhp_pkg::REG_IRQ_EN);
  wire logic is_glob  = (acc.addr >= lhp_pkg::GLOB_BASE) && (acc.addr <= lhp_pkg::GLOB_LAST);
  wire logic is_test  = (acc.addr >= lhp_pkg::TEST_BASE) && (acc.addr <= lhp_pkg::TEST_LAST);
  wire logic is_rsv   = (acc.addr >= lhp_pkg::RSV_BASE) && (acc.addr <= lhp_pkg::RSV_LAST);
  wire logic is_id    = (acc.addr == lhp_pkg::ID_ADDR);
  wire logic is_rev   = (acc.addr == lhp_pkg::REV_ADDR);
  // read-only and read-clear bytes are not storage
  wire logic rw_loc   = (in_chan && !is_live && !is_latch && !is_closs) || is_glob || is_test;
  wire logic mem_we   = (state == lhp_pkg::ST_TAKE) && !acc.rd && rw_loc;
  wire logic mem_re   = (state == lhp_pkg::ST_TAKE) && acc.rd;

  logic [lhp_pkg::DATA_W-1:0] mem_q;

  lhp_regmem #(
    .AW (lhp_pkg::ADDR_W),
    .DW (lhp_pkg::DATA_W)
  ) u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .we_i    (mem_we),
    .waddr_i (acc.addr),
    .wdata_i (acc.data),
    .re_i    (mem_re),
    .raddr_i (acc.addr),
    .rdata_o (mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt enables, global enable, alarm flags

  logic [NUM_CH-1:0][lhp_pkg::FLAG_W-1:0] irq_en;
  logic [NUM_CH-1:0][lhp_pkg::FLAG_W-1:0] latched;
  logic [NUM_CH-1:0][lhp_pkg::FLAG_W-1:0] live_q;
  logic                                   global_irq_enable;
  logic [NUM_CH-1:0]                      ch_pend;

  wire logic glob0_we = mem_we && (acc.addr == lhp_pkg::GLOB_BASE);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_irq_enable <= 1'b0;
    end else if (ce_i && glob0_we) begin
      global_irq_enable <= acc.data[lhp_pkg::GLOBAL_IRQ_ENABLE_BIT];
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    wire logic [lhp_pkg::FLAG_W-1:0] rise = alarm_live_i[c] & ~live_q[c];
    // read of the latched byte clears it; a new event wins
    wire logic clr = (state == lhp_pkg::ST_LOAD) && acc.rd && is_latch && (ch_idx == 2'(c));
    wire logic [lhp_pkg::FLAG_W-1:0] next_latched = (clr ? '0 : latched[c]) | rise;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        irq_en[c]  <= '0;
        latched[c] <= '0;
        live_q[c]  <= '0;
      end else if (ce_i) begin
        live_q[c]  <= alarm_live_i[c];
        latched[c] <= next_latched;
        if (mem_we && is_irqen && (ch_idx == 2'(c))) begin
          irq_en[c] <= acc.data[lhp_pkg::FLAG_W-1:0];
        end
      end
    end

    // pending only where flag and enable meet
    assign ch_pend[c] = |(latched[c] & irq_en[c]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and handshake

  wire logic [lhp_pkg::DATA_W-1:0] live_byte  = {1'b0, alarm_live_i[ch_idx]};
  wire logic [lhp_pkg::DATA_W-1:0] latch_byte = {1'b0, latched[ch_idx]};
  wire logic [lhp_pkg::DATA_W-1:0] closs_byte = {2'b00, cable_loss_i[ch_idx]};
  wire logic [lhp_pkg::DATA_W-1:0] rd_byte =
      is_live  ? live_byte  :
      is_latch ? latch_byte :
      is_closs ? closs_byte :
      is_id    ? DEVICE_ID  :
      is_rev   ? REVISION   :
      is_rsv   ? lhp_pkg::ZERO_BYTE : mem_q;

  wire logic load_end = (state == lhp_pkg::ST_LOAD);
  wire logic done_end = (state == lhp_pkg::ST_DONE) && !access_on;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o                  <= lhp_pkg::RST_BYTE;
      data_oe_n_o             <= 1'b1;
      access_done_handshake_o <= 1'b0;
      irq_n_o                 <= 1'b1;
    end else if (ce_i) begin
      // interrupt gated by the global enable
      irq_n_o <= !(global_irq_enable && |ch_pend);
      if (load_end) begin
        data_o      <= acc.rd ? rd_byte : lhp_pkg::ZERO_BYTE;
        data_oe_n_o <= !acc.rd;
        access_done_handshake_o <= !style_dir;
      end else if (done_end || state == lhp_pkg::ST_IDLE) begin
        data_oe_n_o             <= 1'b1;
        access_done_handshake_o <= style_dir;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_read_drives: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_LOAD && ce_i && acc.rd) |=> !data_oe_n_o)
    else $error("read answer not driven");

  chk_write_quiet: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_DONE && !acc.rd) |-> data_oe_n_o)
    else $error("data driven during write");

  chk_dir_taken: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_TAKE && $past(state) == lhp_pkg::ST_IDLE && style_dir)
      |-> acc.rd == $past(host_i.wr_rw))
    else $error("direction not taken from direction line");

  chk_ready_high: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_LOAD && ce_i && !style_dir)
      |=> access_done_handshake_o && state == lhp_pkg::ST_DONE)
    else $error("ready not raised at completion");

  chk_ack_low: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_LOAD && ce_i && style_dir) |=> !access_done_handshake_o)
    else $error("acknowledge not lowered at completion");

  chk_irq_blocked: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !global_irq_enable) |=> irq_n_o)
    else $error("interrupt active while globally blocked");

  chk_rsv_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_LOAD && ce_i && acc.rd && is_rsv) |=> data_o == lhp_pkg::ZERO_BYTE)
    else $error("reserved location read nonzero");

  chk_id_value: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_LOAD && ce_i && acc.rd && is_id) |=> data_o == DEVICE_ID)
    else $error("identity byte wrong");

  chk_latch_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_LOAD && ce_i && acc.rd && is_latch
      && (alarm_live_i[ch_idx] & ~live_q[ch_idx]) == '0)
      |=> latched[$past(ch_idx)] == '0)
    else $error("latched flags survived a read");

  chk_ro_ignored: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_TAKE && (is_live || is_closs || is_latch)) |-> !mem_we)
    else $error("write reached a read-only byte");

  chk_done_stands: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_DONE && ce_i && access_on && !style_dir)
      |=> access_done_handshake_o)
    else $error("ready dropped before release");

  chk_ack_stands: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_DONE && ce_i && access_on && style_dir)
      |=> !access_done_handshake_o)
    else $error("acknowledge dropped before release");

  chk_release_idle: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_DONE && ce_i && !access_on)
      |=> data_oe_n_o && state == lhp_pkg::ST_IDLE)
    else $error("data still driven after release");

  chk_irq_follows: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && global_irq_enable && |ch_pend) |=> !irq_n_o)
    else $error("enabled alarm did not raise interrupt");

  chk_rev_value: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_LOAD && ce_i && acc.rd && is_rev) |=> data_o == REVISION)
    else $error("revision byte wrong");

  chk_glob_enable: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == lhp_pkg::ST_TAKE && ce_i && !acc.rd && acc.addr == lhp_pkg::GLOB_BASE)
      |=> global_irq_enable == acc.data[lhp_pkg::GLOBAL_IRQ_ENABLE_BIT])
    else $error("global enable not taken from command byte");

  chk_ce_freeze: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !ce_i |=> state == $past(state))
    else $error("state moved while clock enable low");

endmodule

// >>> shared/lhp_pkg.sv
// shared constants, types and register map of the line interface host port
package lhp_pkg;

  localparam int ADDR_W  = 7;
  localparam int DATA_W  = 8;
  localparam int PIN_A_W = 8;
  localparam int FLAG_W  = 7;
  localparam int CLOSS_W = 6;

  // per-channel bank offsets
  localparam logic [3:0] REG_IRQ_EN = 4'h4;
  localparam logic [3:0] REG_LIVE   = 4'h5;
  localparam logic [3:0] REG_LATCH  = 4'h6;
  localparam logic [3:0] REG_CLOSS  = 4'h7;

  // global map
  localparam logic [ADDR_W-1:0] CH_LAST   = 7'h3F;
  localparam logic [ADDR_W-1:0] GLOB_BASE = 7'h40;
  localparam logic [ADDR_W-1:0] GLOB_LAST = 7'h43;
  localparam logic [ADDR_W-1:0] TEST_BASE = 7'h44;
  localparam logic [ADDR_W-1:0] TEST_LAST = 7'h4B;
  localparam logic [ADDR_W-1:0] RSV_BASE  = 7'h4C;
  localparam logic [ADDR_W-1:0] RSV_LAST  = 7'h7D;
  localparam logic [ADDR_W-1:0] ID_ADDR   = 7'h7E;
  localparam logic [ADDR_W-1:0] REV_ADDR  = 7'h7F;

  localparam int GLOBAL_IRQ_ENABLE_BIT = 1;

  localparam logic [DATA_W-1:0] RST_BYTE  = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  // bus styles
  localparam logic STYLE_SPLIT = 1'b0;
  localparam logic STYLE_DIR   = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_TAKE = 2'h1,
    ST_LOAD = 2'h3,
    ST_DONE = 2'h2
  } lhp_state_t;

  // host pins, all synchronous to the core clock
  typedef struct packed {
    logic               cs_n;
    logic               read_or_data_strobe_n;
    logic               wr_rw;
    logic [PIN_A_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } lhp_pins_t;

  // one access as taken
  typedef struct packed {
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } lhp_acc_t;

endpackage

// >>> rtl/lhp_regmem.sv
// byte-wide register storage with registered read data
`timescale 1ns/1ps
module lhp_regmem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem[i] <= '0;
      end
      rdata_o <= '0;
    end else if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      if (re_i) begin
        rdata_o <= mem[raddr_i];
      end
    end
  end

endmodule

// >>> dv/lhp_host_model.sv
// host processor model driving single byte accesses on the parallel port
`timescale 1ns/1ps
module lhp_host_model (
  input  wire logic                       clk_i,
  input  wire logic                       style_i,
  input  wire logic                       done_i,
  input  wire logic                       oe_n_i,
  input  wire logic [lhp_pkg::DATA_W-1:0] data_i,
  output lhp_pkg::lhp_pins_t              host_o
);
  initial begin
    host_o = '{cs_n: 1'b1, read_or_data_strobe_n: 1'b1, wr_rw: 1'b1, addr: 8'hFF, data: 8'hFF};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one access: launch, hold until done is sampled, take data, then release
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic oe_n, output int lat);
    logic hit;
    hit  = 1'b0;
    lat  = 0;
    repeat (2) @(posedge clk_i);
    host_o.cs_n    <= 1'b0;
    host_o.read_or_data_strobe_n <= style_i ? 1'b0 : !rd;
    host_o.wr_rw   <= rd;
    host_o.addr    <= a;
    host_o.data    <= d;
    while (!hit && lat < 20) begin
      @(posedge clk_i);
      lat++;
      hit = (done_i === !style_i);
    end
    q    = data_i;
    oe_n = oe_n_i;
    // released address and data lines show the inverse of their last value; strobes and select go high
    host_o.cs_n    <= 1'b1;
    host_o.read_or_data_strobe_n <= 1'b1;
    host_o.wr_rw   <= 1'b1;
    host_o.addr    <= ~a;
    host_o.data    <= ~d;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// >>> dv/tb_lineif_host_register_port.sv
// self-checking bench of the line interface host port
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_lineif_host_register_port;
  typedef struct packed {
    logic [1:0] pad;
    logic       st;
    logic       rd;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] x;
  } lhp_row_t;
  localparam int NROW = 21;

  logic                      clk_i;
  logic                      rst_n_i;
  logic                      ce_i;
  logic                      bus_style_i;
  lhp_pkg::lhp_pins_t        host;
  logic [3:0][6:0]           alarm_live_i;
  logic [3:0][5:0]           cable_loss_i;
  logic [7:0]                data_o;
  logic                      oe_n;
  logic                      hs;
  logic                      irq_n_o;
  logic [7:0]                q;
  logic                      oe;
  int                        lat;
  int                        error_cnt;
  int                        cmp_count;

  // style/rd nibble, address, write data, expected data
  lhp_row_t rows [NROW] = '{
    28'h0_00_A5_00, 28'h1_00_00_A5, 28'h2_10_3C_00, 28'h3_10_00_3C,
    28'h0_20_11_00, 28'h2_3F_22_00, 28'h1_20_00_11, 28'h3_3F_00_22,
    28'h1_00_00_A5, 28'h0_43_77_00, 28'h3_43_00_77, 28'h0_4B_81_00,
    28'h1_4B_00_81, 28'h2_4C_55_00, 28'h3_4C_00_00, 28'h0_7E_00_00,
    28'h1_7E_00_5A, 28'h3_7F_00_01, 28'h0_07_FF_00, 28'h1_07_00_2A,
    28'h3_80_00_A5};

  // identity and revision values are arbitrary
  lhp_host_port #(.NUM_CH(4), .DEVICE_ID(8'h5A), .REVISION(8'h01)) uut (
    .clk_i                   (clk_i),
    .rst_n_i                 (rst_n_i),
    .ce_i                    (ce_i),
    .bus_style_i             (bus_style_i),
    .host_i                  (host),
    .alarm_live_i            (alarm_live_i),
    .cable_loss_i            (cable_loss_i),
    .data_o                  (data_o),
    .data_oe_n_o             (oe_n),
    .access_done_handshake_o (hs),
    .irq_n_o                 (irq_n_o)
  );

  lhp_host_model host_m (
    .clk_i   (clk_i),
    .style_i (bus_style_i),
    .done_i  (hs),
    .oe_n_i  (oe_n),
    .data_i  (data_o),
    .host_o  (host)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic final_report;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_irq(input logic lvl);
    for (int k = 0; k < 10 && irq_n_o !== lvl; k++) @(posedge clk_i);
  endtask

  task automatic rw(input logic rd, input logic [7:0] a, input logic [7:0] d);
    host_m.xfer(rd, a, d, q, oe, lat);
  endtask

  initial begin
    #40000;
    error_cnt++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt    = 0;
    cmp_count    = 0;
    rst_n_i      = 1'b0;
    ce_i         = 1'b1;
    bus_style_i  = 1'b0;
    alarm_live_i = '0;
    cable_loss_i = 24'h00002A;
    repeat (12) @(posedge clk_i);
    `CHK(oe_n, 1'b1)
    `CHK(irq_n_o, 1'b1)
    `CHK(data_o, 8'h00)
    rst_n_i <= 1'b1;
    for (int i = 0; i < NROW; i++) begin
      bus_style_i <= rows[i].st;
      rw(rows[i].rd, rows[i].a, rows[i].d);
      `CHK(q, rows[i].x)
      `CHK(oe, !rows[i].rd)
      `CHK(lat, 4)
      `CHK(hs, rows[i].st)
    end
    // clock enable low for four edges in mid-access stretches the answer
    fork
      rw(1'b1, 8'h10, 8'h00);
      begin
        repeat (3) @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    `CHK(q, 8'h3C)
    `CHK(lat, 8)
    // enabled alarm held off by the global enable, then let through
    bus_style_i <= 1'b0;
    rw(1'b0, 8'h14, 8'h40);
    alarm_live_i[1][6] <= 1'b1;
    wait_irq(1'b0);
    `CHK(irq_n_o, 1'b1)
    rw(1'b0, 8'h40, 8'h02);
    wait_irq(1'b0);
    `CHK(irq_n_o, 1'b0)
    rw(1'b1, 8'h15, 8'h00);
    `CHK(q, 8'h40)
    rw(1'b1, 8'h16, 8'h00);
    `CHK(q, 8'h40)
    wait_irq(1'b1);
    `CHK(irq_n_o, 1'b1)
    rw(1'b1, 8'h16, 8'h00);
    `CHK(q, 8'h00)
    // latched flag without its enable keeps the pin quiet
    alarm_live_i[2][1] <= 1'b1;
    rw(1'b0, 8'h25, 8'hFF);
    wait_irq(1'b0);
    `CHK(irq_n_o, 1'b1)
    rw(1'b1, 8'h25, 8'h00);
    `CHK(q, 8'h02)
    rw(1'b0, 8'h24, 8'h02);
    wait_irq(1'b0);
    `CHK(irq_n_o, 1'b0)
    // reset in mid-run clears outputs and registers
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(irq_n_o, 1'b1)
    `CHK(oe_n, 1'b1)
    rst_n_i <= 1'b1;
    rw(1'b1, 8'h00, 8'h00);
    `CHK(q, 8'h00)
    rw(1'b1, 8'h40, 8'h00);
    `CHK(q, 8'h00)
    final_report;
  end
endmodule
